// ==== fdc_counter.sv ====
// four-decade up/down counter with compare register, store latch and display scan
// Function
// - presettable four-decade up/down counter
// - settable register compared with count continuously
// - equal indication when count matches register
// - decade option counts 0000 to 9999
// - timing option tops out at 5959
// - display and bcd output from store latches
// - multiplexed seven-segment drive, one digit active
// - each digit lit a quarter of scan
// - leading zeros blanked on display
// - carry/borrow output for cascading counters
// - zero indication decoded from all digits
// - three-state bcd port, digit multiplexed
// - internal scan oscillator, rate externally settable
// - carry pulse on 9999/0000 wraps, 5959/0000 wraps in timing option
// - equal output active low
// - zero output active low
// - reset at 6000 or above pulses carry
`timescale 1ns/1ps
module fdc_counter #(
   parameter bit          TIMING_OPT = 1'b0,              // 1: 5959 timing counter
   parameter int unsigned SCAN_DIV   = fdc_pkg::SCAN_DIV  // default digit slot length
) (
   input  wire logic       SYS_CLK_I,          // system clock
   input  wire logic       RST_N_I,            // synchronous reset, active low
   input  wire logic       COUNT_I,            // count pin
   input  wire logic       COUNT_DIRECTION_I,  // 1 up, 0 down
   input  wire logic       CNT_RESET_N_I,      // counter reset pin, active low
   input  wire logic       STORE_N_I,          // store pin, active low
   input  wire logic       LOAD_COUNT_N_I,     // load counter from bcd port, active low
   input  wire logic       LOAD_REG_N_I,       // load register from bcd port, active low
   input  wire logic       BLANK_LZ_I,         // enable leading zero blanking
   input  wire logic [15:0] SCAN_DIV_I,        // external scan rate, 0 = free-running
   input  wire logic [3:0] BCD_I,              // bcd port input side
   output logic      [3:0] BCD_O,              // bcd port output side
   output logic            BCD_OE_O,           // high while driving the bcd port
   output logic      [6:0] SEG_O,              // segment lines
   output logic      [3:0] DIGIT_O,            // digit enables, one hot
   output logic            CARRY_O,            // carry/borrow pulse
   output logic            EQUAL_N_O,          // low while count equals register
   output logic            ZERO_N_O            // low while count is zero
);
   // scan slot states, one-hot
   typedef enum logic [3:0] {
      FDC_SLOT0 = 4'b0001,
      FDC_SLOT1 = 4'b0010,
      FDC_SLOT2 = 4'b0100,
      FDC_SLOT3 = 4'b1000
   } fdc_slot_e;

   // synchronisers for pins
   logic [1:0]       cnt_sync_q;        // count pin
   logic             cnt_prev_q;        // edge detector history
   logic [1:0]       dir_sync_q;
   logic [1:0]       rst_sync_q;
   logic [1:0]       st_sync_q;
   logic [1:0]       lc_sync_q;
   logic [1:0]       lr_sync_q;
   logic [1:0]       lz_sync_q;
   logic [3:0]       bcd_s1_q;
   logic [3:0]       bcd_s2_q;
   logic             cnt_rise;          // one-cycle count event

   fdc_pkg::fdc_count_s count_q;        // live counter
   fdc_pkg::fdc_count_s count_d;
   fdc_pkg::fdc_count_s cmp_q;          // compare register
   fdc_pkg::fdc_count_s latch_q;        // display/output latches
   fdc_pkg::fdc_flags_s flags_q;        // registered indications
   logic             wrap;              // counter wraps this step

   fdc_slot_e        slot_q;            // active digit
   logic [15:0]      tick_cnt_q;        // slot timer
   logic [15:0]      slot_len;          // chosen slot length
   logic [3:0]       cur_digit;         // latched digit in active slot
   logic             cur_blank;         // leading-zero blank for active slot
   logic             loading;           // port is an input

   // digit limits per position
   function automatic logic [3:0] dig_max(input int unsigned pos);
      if (TIMING_OPT && (pos == 1 || pos == 3)) begin
         dig_max = fdc_pkg::DIG_MAX_TEN;
      end else begin
         dig_max = fdc_pkg::DIG_MAX_DEC;
      end
   endfunction

   // digit select by slot index
   function automatic logic [3:0] pick(input fdc_pkg::fdc_count_s c, input fdc_slot_e s);
      unique case (s)
         FDC_SLOT0: pick = c.d0;
         FDC_SLOT1: pick = c.d1;
         FDC_SLOT2: pick = c.d2;
         FDC_SLOT3: pick = c.d3;
      endcase
   endfunction

   // two-stage synchronisers on every pin input
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         cnt_sync_q <= 2'h0;
         cnt_prev_q <= 1'b0;
         dir_sync_q <= 2'h3;
         rst_sync_q <= 2'h3;
         st_sync_q  <= 2'h3;
         lc_sync_q  <= 2'h3;
         lr_sync_q  <= 2'h3;
         lz_sync_q  <= 2'h0;
         bcd_s1_q   <= 4'h0;
         bcd_s2_q   <= 4'h0;
      end else begin
         cnt_sync_q <= {cnt_sync_q[0], COUNT_I};
         cnt_prev_q <= cnt_sync_q[1];
         dir_sync_q <= {dir_sync_q[0], COUNT_DIRECTION_I};
         rst_sync_q <= {rst_sync_q[0], CNT_RESET_N_I};
         st_sync_q  <= {st_sync_q[0], STORE_N_I};
         lc_sync_q  <= {lc_sync_q[0], LOAD_COUNT_N_I};
         lr_sync_q  <= {lr_sync_q[0], LOAD_REG_N_I};
         lz_sync_q  <= {lz_sync_q[0], BLANK_LZ_I};
         bcd_s1_q   <= BCD_I;
         bcd_s2_q   <= bcd_s1_q;
      end
   end

   assign cnt_rise = cnt_sync_q[1] & ~cnt_prev_q;
   assign loading  = ~lc_sync_q[1] | ~lr_sync_q[1];

   // next count: ripple through digits with per-digit limits
   always_comb begin
      logic [3:0] dv [4];
      logic       c;
      dv[0] = count_q.d0;
      dv[1] = count_q.d1;
      dv[2] = count_q.d2;
      dv[3] = count_q.d3;
      c     = 1'b1;
      for (int unsigned i = 0; i < fdc_pkg::DIGITS; i++) begin
         if (c) begin
            if (dir_sync_q[1]) begin
               c     = (dv[i] >= dig_max(i));
               dv[i] = c ? 4'h0 : 4'(dv[i] + 4'h1);
            end else begin
               c     = (dv[i] == 4'h0);
               dv[i] = c ? dig_max(i) : 4'(dv[i] - 4'h1);
            end
         end
      end
      wrap    = c;
      count_d = '{d3: dv[3], d2: dv[2], d1: dv[1], d0: dv[0]};
   end

   // counter: reset, load, then count; one step per edge
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I || !rst_sync_q[1]) begin
         count_q <= fdc_pkg::COUNT_ZERO;
      end else if (!lc_sync_q[1]) begin
         // whole slot: digit sampled in its scan slot
         unique case (slot_q)
            FDC_SLOT0: count_q.d0 <= bcd_s2_q;
            FDC_SLOT1: count_q.d1 <= bcd_s2_q;
            FDC_SLOT2: count_q.d2 <= bcd_s2_q;
            FDC_SLOT3: count_q.d3 <= bcd_s2_q;
         endcase
      end else if (cnt_rise) begin
         count_q <= count_d;
      end
   end

   // compare register loaded digit by digit from the port
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         cmp_q <= fdc_pkg::COUNT_ZERO;
      end else if (!lr_sync_q[1]) begin
         unique case (slot_q)
            FDC_SLOT0: cmp_q.d0 <= bcd_s2_q;
            FDC_SLOT1: cmp_q.d1 <= bcd_s2_q;
            FDC_SLOT2: cmp_q.d2 <= bcd_s2_q;
            FDC_SLOT3: cmp_q.d3 <= bcd_s2_q;
         endcase
      end
   end

   // store latches follow the counter only while store is held low
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         latch_q <= fdc_pkg::COUNT_ZERO;
      end else if (!st_sync_q[1]) begin
         latch_q <= count_q;
      end
   end

   // indications, registered so outputs are glitch free
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         flags_q <= '{zero_n: 1'b1, equal_n: 1'b1, carry: 1'b0};
      end else begin
         flags_q.zero_n  <= ~(count_q == fdc_pkg::COUNT_ZERO);
         flags_q.equal_n <= ~(count_q == cmp_q);
         // carry not meaningful during load; reset from 6000+ still pulses
         if (!rst_sync_q[1]) begin
            flags_q.carry <= (count_q.d3 >= fdc_pkg::THRESH_DIG);
         end else begin
            flags_q.carry <= cnt_rise & wrap & lc_sync_q[1];
         end
      end
   end

   assign CARRY_O   = flags_q.carry;
   assign EQUAL_N_O = flags_q.equal_n;
   assign ZERO_N_O  = flags_q.zero_n;

   // scan oscillator: external divider if nonzero, else free-running
   assign slot_len = (SCAN_DIV_I != 16'h0) ? SCAN_DIV_I : 16'(SCAN_DIV);

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         tick_cnt_q <= 16'h0;
         slot_q     <= FDC_SLOT0;
      end else if (tick_cnt_q >= 16'(slot_len - 16'h1)) begin
         tick_cnt_q <= 16'h0;
         // equal slots, so each digit gets a quarter
         unique case (slot_q)
            FDC_SLOT0: slot_q <= FDC_SLOT1;
            FDC_SLOT1: slot_q <= FDC_SLOT2;
            FDC_SLOT2: slot_q <= FDC_SLOT3;
            FDC_SLOT3: slot_q <= FDC_SLOT0;
         endcase
      end else begin
         tick_cnt_q <= 16'(tick_cnt_q + 16'h1);
      end
   end

   // leading zero blank: zero with all higher digits zero; units always shown
   always_comb begin
      cur_digit = pick(latch_q, slot_q);
      unique case (slot_q)
         FDC_SLOT3: cur_blank = (latch_q.d3 == 4'h0);
         FDC_SLOT2: cur_blank = (latch_q.d3 == 4'h0) && (latch_q.d2 == 4'h0);
         FDC_SLOT1: cur_blank = (latch_q[15:4] == 12'h0);
         FDC_SLOT0: cur_blank = 1'b0;
      endcase
      cur_blank = cur_blank & lz_sync_q[1];
   end

   // segment decode
   logic [6:0] seg_d;
   fdc_seg_dec u_seg (
      .digit_i (cur_digit),
      .blank_i (cur_blank),
      .seg_o   (seg_d)
   );

   // display and port drivers registered; port released while loading
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         SEG_O    <= fdc_pkg::SEG_BLANK;
         DIGIT_O  <= 4'h0;
         BCD_O    <= 4'h0;
         BCD_OE_O <= 1'b0;
      end else begin
         SEG_O    <= seg_d;
         DIGIT_O  <= slot_q;
         BCD_O    <= cur_digit;
         BCD_OE_O <= ~loading;
      end
   end
endmodule

// ==== fdc_pkg.sv ====
// shared constants and types for the four-decade compare counter
package fdc_pkg;
   localparam int unsigned CLK_HZ      = 125000000;   // system clock rate
   localparam int unsigned SCAN_HZ     = 2500;        // free-running scan rate
   localparam int unsigned SCAN_DIV    = CLK_HZ / SCAN_HZ / 4; // cycles per digit slot
   localparam int unsigned DIGITS      = 4;
   localparam logic [3:0]  DIG_MAX_DEC = 4'h9;        // decade digit limit
   localparam logic [3:0]  DIG_MAX_TEN = 4'h5;        // tens digit limit in timing option
   localparam logic [3:0]  THRESH_DIG  = 4'h6;        // top digit at or above 6 means 6000+
   localparam logic [6:0]  SEG_BLANK   = 7'h00;

   // four bcd digits, digit 0 least significant
   typedef struct packed {
      logic [3:0] d3;
      logic [3:0] d2;
      logic [3:0] d1;
      logic [3:0] d0;
   } fdc_count_s;

   // indications derived from the count
   typedef struct packed {
      logic zero_n;
      logic equal_n;
      logic carry;
   } fdc_flags_s;

   localparam fdc_count_s COUNT_ZERO = '{default: 4'h0};
endpackage

// ==== fdc_seg_dec.sv ====
// bcd to seven-segment decoder with blanking
`timescale 1ns/1ps
module fdc_seg_dec (
   input  wire logic [3:0] digit_i,   // bcd value
   input  wire logic       blank_i,   // force all segments off
   output logic      [6:0] seg_o      // segments g..a, active high
);
   // plain lookup; codes above 9 show dark
   always_comb begin
      if (blank_i) begin
         seg_o = fdc_pkg::SEG_BLANK;
      end else begin
         unique case (digit_i)
            4'h0:    seg_o = 7'h3f;
            4'h1:    seg_o = 7'h06;
            4'h2:    seg_o = 7'h5b;
            4'h3:    seg_o = 7'h4f;
            4'h4:    seg_o = 7'h66;
            4'h5:    seg_o = 7'h6d;
            4'h6:    seg_o = 7'h7d;
            4'h7:    seg_o = 7'h07;
            4'h8:    seg_o = 7'h7f;
            4'h9:    seg_o = 7'h6f;
            default: seg_o = fdc_pkg::SEG_BLANK;
         endcase
      end
   end
endmodule

// ==== fdc_counter_monitor.sv ====
// port assertions for the four-decade compare counter
`timescale 1ns/1ps
module fdc_counter_monitor #(
   parameter int unsigned SCAN_DIV = 4  // digit slot length
) (
   input wire logic       SYS_CLK_I,
   input wire logic       RST_N_I,
   input wire logic       COUNT_I,
   input wire logic       CNT_RESET_N_I,
   input wire logic       LOAD_COUNT_N_I,
   input wire logic       LOAD_REG_N_I,
   input wire logic       BLANK_LZ_I,
   input wire logic [3:0] BCD_O,
   input wire logic       BCD_OE_O,
   input wire logic [6:0] SEG_O,
   input wire logic [3:0] DIGIT_O,
   input wire logic       CARRY_O,
   input wire logic       EQUAL_N_O,
   input wire logic       ZERO_N_O
);
   logic [3:0]  prev_q;  // digit enables one cycle ago
   logic [15:0] run_q;   // cycles the slot has lasted
   logic [1:0]  seen_q;  // slot changes, first slot is partial
   // slot length bookkeeping
   always_ff @(posedge SYS_CLK_I) begin
      prev_q <= RST_N_I ? DIGIT_O : 4'h0;
      if (!RST_N_I || DIGIT_O != prev_q) begin
         run_q <= 16'h0;
      end else begin
         run_q <= run_q + 16'h1;
      end
      if (!RST_N_I) begin
         seen_q <= 2'h0;
      end else if (DIGIT_O != prev_q && seen_q != 2'h2) begin
         seen_q <= seen_q + 2'h1;
      end
   end
   chk_digit_onehot: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $past(RST_N_I) |-> $onehot(DIGIT_O)) else $error("digit enable not one hot");
   chk_slot_len: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      DIGIT_O != prev_q && seen_q == 2'h2 |-> run_q == SCAN_DIV - 1)
      else $error("digit slot length wrong");
   chk_lz_blank: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      DIGIT_O[3] && BCD_O == 4'h0 && BLANK_LZ_I == $past(BLANK_LZ_I, 4)
      |-> (SEG_O == fdc_pkg::SEG_BLANK) == BLANK_LZ_I) else $error("leading zero blanking");
   chk_seg_lit: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $onehot(DIGIT_O) && BCD_O != 4'h0 |-> SEG_O != fdc_pkg::SEG_BLANK)
      else $error("nonzero digit dark");
   chk_carry_single: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      CARRY_O |=> !CARRY_O) else $error("carry longer than one cycle");
   chk_carry_cause: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $rose(CARRY_O) |-> $past(COUNT_I, 3) || $past(COUNT_I, 4) || $past(COUNT_I, 5)
      || !$past(CNT_RESET_N_I, 2) || !$past(CNT_RESET_N_I, 3) || !$past(CNT_RESET_N_I, 4))
      else $error("carry without cause");
   chk_load_quiet: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (!LOAD_COUNT_N_I)[*4] |-> !CARRY_O) else $error("carry during load");
   chk_oe_load: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (!LOAD_COUNT_N_I || !LOAD_REG_N_I)[*4] |-> !BCD_OE_O) else $error("port driven in load");
   chk_oe_idle: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (LOAD_COUNT_N_I && LOAD_REG_N_I)[*6] |-> BCD_OE_O) else $error("port not driven");
   chk_reset_state: assert property (@(posedge SYS_CLK_I)
      !RST_N_I |=> !CARRY_O && EQUAL_N_O && ZERO_N_O && !BCD_OE_O)
      else $error("outputs not in reset state");
endmodule

// ==== fdc_panel_model.sv ====
// thumbwheel switches on the shared bcd port
`timescale 1ns/1ps
module fdc_panel_model (
   input  wire logic        clk_i,    // system clock
   input  wire logic [3:0]  digit_i,  // scan slot, one hot
   input  wire logic [3:0]  dev_i,    // device side of the port
   input  wire logic        dev_oe_i, // device drives the port
   input  wire logic        sw_en_i,  // switch common enabled
   input  wire logic [15:0] sw_i,     // four switch digits
   output logic      [3:0]  wire_o    // level on the port wire
);
   logic [3:0] last_q;         // last wire level
   logic [1:0] idx;            // slot number
   assign idx = digit_i[3] ? 2'h3 : digit_i[2] ? 2'h2 : {1'b0, digit_i[1]};
   // floating wire toggles so a stale digit is never read as valid
   assign wire_o = dev_oe_i ? dev_i : sw_en_i ? sw_i[idx*4 +: 4] : ~last_q;
   always_ff @(posedge clk_i) last_q <= wire_o;
endmodule

// ==== test_four_decade_updown_compare_counter.sv ====
// self-checking bench for the four-decade compare counter
`timescale 1ns/1ps
module test_four_decade_updown_compare_counter;
   localparam int unsigned SDIV = 4;  // short digit slot
   typedef struct packed {
      logic dir; logic [7:0] n; logic [15:0] cnt; logic [15:0] cy; logic [15:0] tcnt;
   } fdc_row_s;
   // last column: what the timing build shows after the same steps
   fdc_row_s rows [4] = '{'{1'b0, 8'h01, 16'h9999, 16'h1, 16'h5959},
                          '{1'b1, 8'h01, 16'h0000, 16'h1, 16'h0000},
                          '{1'b1, 8'h0c, 16'h0012, 16'h0, 16'h0012},
                          '{1'b0, 8'h03, 16'h0009, 16'h0, 16'h0009}};
   logic        carry_t;      // timing build carry
   logic [3:0]  bcd_t, dig_t; // timing build port and digit enables
   logic [15:0] vt;           // timing build latched value
   int ccnt_t, ct0;
   logic clk, rst_n, cnt_pin, dir, crst_n, st_n, ldc_n, ldr_n, blz, sw_en, oe, carry, eq_n, z_n;
   logic [3:0]  bcd_i, bcd_o, dig;
   logic [6:0]  seg;
   logic [15:0] sw, v;
   int err_count, num_checks, ccnt, c0, cyc;
   fdc_counter #(.TIMING_OPT(1'b0), .SCAN_DIV(SDIV)) u_dut (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .COUNT_I(cnt_pin), .COUNT_DIRECTION_I(dir),
      .CNT_RESET_N_I(crst_n), .STORE_N_I(st_n), .LOAD_COUNT_N_I(ldc_n), .LOAD_REG_N_I(ldr_n),
      .BLANK_LZ_I(blz), .SCAN_DIV_I(16'h0004), .BCD_I(bcd_i), .BCD_O(bcd_o), .BCD_OE_O(oe),
      .SEG_O(seg), .DIGIT_O(dig), .CARRY_O(carry), .EQUAL_N_O(eq_n), .ZERO_N_O(z_n));
   fdc_panel_model u_panel (.clk_i(clk), .digit_i(dig), .dev_i(bcd_o), .dev_oe_i(oe),
      .sw_en_i(sw_en), .sw_i(sw), .wire_o(bcd_i));
   // timing build on the same pins, scan left free-running
   fdc_counter #(.TIMING_OPT(1'b1), .SCAN_DIV(SDIV)) u_dut_t (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .COUNT_I(cnt_pin), .COUNT_DIRECTION_I(dir),
      .CNT_RESET_N_I(crst_n), .STORE_N_I(st_n), .LOAD_COUNT_N_I(ldc_n), .LOAD_REG_N_I(ldr_n),
      .BLANK_LZ_I(blz), .SCAN_DIV_I(16'h0000), .BCD_I(bcd_i), .BCD_O(bcd_t), .BCD_OE_O(),
      .SEG_O(), .DIGIT_O(dig_t), .CARRY_O(carry_t), .EQUAL_N_O(), .ZERO_N_O());
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (carry === 1'b1) ccnt++;
      if (carry_t === 1'b1) ccnt_t++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   task automatic results();
      if (err_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // count pulses high and low four clocks each
   task automatic pulse(input logic d, input int n);
      dir <= d;
      tick(4);
      repeat (n) begin
         cnt_pin <= 1'b1;
         tick(4);
         cnt_pin <= 1'b0;
         tick(4);
      end
      tick(4);
   endtask
   // store, then gather one full scan of latched digits
   task automatic rd(output logic [15:0] r, output logic [15:0] rt);
      st_n <= 1'b0;
      tick(4);
      st_n <= 1'b1;
      tick(4);
      repeat (4 * SDIV + 4) begin
         tick(1);
         #1;
         for (int i = 0; i < 4; i++) begin
            if (dig[i]) r[i*4 +: 4] = bcd_o;
            if (dig_t[i]) rt[i*4 +: 4] = bcd_t;
         end
      end
   endtask
   task automatic seg_at(input int i, input logic [6:0] e);
      int k;
      k = 0;
      while (dig[i] !== 1'b1 && k < 40) begin
         tick(1);
         #1;
         k++;
      end
      chk({9'h0, seg}, {9'h0, e});
   endtask
   // switches held over more than a full scan
   task automatic load(input logic to_reg, input logic [15:0] val);
      sw <= val;
      sw_en <= 1'b1;
      if (to_reg) ldr_n <= 1'b0;
      else ldc_n <= 1'b0;
      tick(6 * SDIV);
      ldr_n <= 1'b1;
      ldc_n <= 1'b1;
      tick(6);
      sw_en <= 1'b0;
      tick(2);
   endtask
   initial begin
      {rst_n, cnt_pin, dir, blz, sw_en} = 5'h0;
      {crst_n, st_n, ldc_n, ldr_n} = 4'hf;
      sw = 16'h0;
      tick(5);
      rst_n <= 1'b1;
      tick(6);
      foreach (rows[r]) begin
         c0 = ccnt;
         ct0 = ccnt_t;
         pulse(rows[r].dir, rows[r].n);
         rd(v, vt);
         chk(v, rows[r].cnt);
         chk(vt, rows[r].tcnt);
         chk(16'(ccnt_t - ct0), rows[r].cy);
         chk(16'(ccnt - c0), rows[r].cy);
         chk({15'h0, z_n}, {15'h0, rows[r].cnt != 16'h0});
         chk({15'h0, eq_n}, {15'h0, rows[r].cnt != 16'h0});
      end
      // preset both, then count onto the register value
      load(1'b1, 16'h0015);
      load(1'b0, 16'h0010);
      chk({15'h0, eq_n}, 16'h1);
      pulse(1'b1, 5);
      chk({15'h0, eq_n}, 16'h0);
      rd(v, vt);
      chk(v, 16'h0015);
      chk(vt, 16'h0015);
      blz <= 1'b1;
      pulse(1'b1, 1);
      seg_at(3, 7'h00);
      seg_at(0, 7'h6d);
      // counter reset at and below the threshold
      for (int j = 0; j < 2; j++) begin
         load(1'b0, j ? 16'h5999 : 16'h6000);
         c0 = ccnt;
         crst_n <= 1'b0;
         tick(6);
         crst_n <= 1'b1;
         tick(6);
         chk(16'(ccnt - c0), j ? 16'h0 : 16'h1);
         chk({15'h0, z_n}, 16'h0);
      end
      // system reset in mid-run
      rst_n <= 1'b0;
      tick(5);
      #1;
      chk({12'h0, dig}, 16'h0);
      rst_n <= 1'b1;
      tick(8);
      chk({15'h0, eq_n}, 16'h0);
      results();
   end
endmodule
bind fdc_counter fdc_counter_monitor #(.SCAN_DIV(SCAN_DIV)) u_mon (
   .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .COUNT_I(COUNT_I), .CNT_RESET_N_I(CNT_RESET_N_I),
   .LOAD_COUNT_N_I(LOAD_COUNT_N_I), .LOAD_REG_N_I(LOAD_REG_N_I), .BLANK_LZ_I(BLANK_LZ_I),
   .BCD_O(BCD_O), .BCD_OE_O(BCD_OE_O), .SEG_O(SEG_O), .DIGIT_O(DIGIT_O), .CARRY_O(CARRY_O),
   .EQUAL_N_O(EQUAL_N_O), .ZERO_N_O(ZERO_N_O));
